// *** pkg/q2sc_map.vh ***
`ifndef Q2SC_MAP_VH
`define Q2SC_MAP_VH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define Q2SC_OFS_CTRL 4'h0
`define Q2SC_OFS_STAT 4'h4
`define Q2SC_OFS_TEST 4'h8

// ****************************************
// queue2_control field positions
// ****************************************
`define Q2SC_CIE_BIT 15
`define Q2SC_PIE_BIT 14
`define Q2SC_ARM_BIT 13
`define Q2SC_MODE_HI 12
`define Q2SC_MODE_LO 8
`define Q2SC_RES_BIT 7
`define Q2SC_BQ_HI 5
`define Q2SC_BQ_LO 0

// ****************************************
// reset values
// ****************************************
`define Q2SC_CTRL_RST 16'h0027
`define Q2SC_BQ_RST 6'h27
`define Q2SC_FLAG_RST 1'b0

// ****************************************
// mode codes
// ****************************************
`define Q2SC_M_OFF 5'h00
`define Q2SC_M_SW_SS 5'h01
`define Q2SC_M_RISE_SS 5'h02
`define Q2SC_M_FALL_SS 5'h03
`define Q2SC_M_IT_LO 5'h04
`define Q2SC_M_IT_HI 5'h0e
`define Q2SC_M_SW_CS 5'h11
`define Q2SC_M_RISE_CS 5'h12
`define Q2SC_M_FALL_CS 5'h13
`define Q2SC_M_PT_LO 5'h14
`define Q2SC_M_PT_HI 5'h1e

// ****************************************
// table size and timer counts
// ****************************************
`define Q2SC_CCW_LAST 6'h27
`define Q2SC_BQ_EMPTY 6'h28
`define Q2SC_EXP_BASE 5'h03
`define Q2SC_TMR_W 18

`endif

// *** src/q2sc_timer.v ***
`timescale 1ns/100ps
`include "q2sc_map.vh"

// interval / periodic timer counting conversion clock periods
module q2sc_timer (
	input wire clk_i,
	input wire rst_i,
	input wire tick_i,
	input wire run_i,
	input wire clear_i,
	input wire [4:0] exp_i,
	output wire expire_o
);

	reg [`Q2SC_TMR_W-1:0] cnt_q;
	reg expire_q;
	reg [`Q2SC_TMR_W-1:0] last_w;

	// terminal count is two to the exponent minus one
	always @* begin
		last_w = {`Q2SC_TMR_W{1'b0}};
		if (exp_i <= 5'd18)
			last_w = ({{(`Q2SC_TMR_W-1){1'b0}}, 1'b1} << exp_i) -
				{{(`Q2SC_TMR_W-1){1'b0}}, 1'b1};
	end

	// clear wins so a new mode always starts a full interval
	always @(posedge clk_i) begin
		expire_q <= 1'b0;
		if (rst_i || clear_i || !run_i) begin
			cnt_q <= {`Q2SC_TMR_W{1'b0}};
		end else if (tick_i) begin
			if (cnt_q == last_w) begin
				cnt_q <= {`Q2SC_TMR_W{1'b0}};
				expire_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q + {{(`Q2SC_TMR_W-1){1'b0}}, 1'b1};
			end
		end
	end

	assign expire_o = expire_q;

endmodule // q2sc_timer

// *** src/q2sc_top.v ***
`timescale 1ns/100ps
`include "q2sc_map.vh"

module q2sc_top (
	input wire clk_i,
	input wire rst_i,
	input wire [3:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output wire [31:0] avs_readdata_o,
	output wire avs_waitrequest_o,
	input wire conversion_clock_tick_i,
	input wire q2_trigger_pin_i,
	input wire q1_active_i,
	input wire q1_fetch_i,
	input wire [5:0] q1_fetch_addr_i,
	input wire q2_suspend_i,
	input wire [5:0] q2_cur_addr_i,
	input wire q2_ccw_done_i,
	input wire q2_ccw_pause_i,
	input wire q2_eoq_i,
	output wire q1_end_o,
	output wire q2_start_o,
	output wire [5:0] q2_start_addr_o,
	output wire [2:0] q2_state_o
);

	// ****************************************
	// states and mode classes
	// ****************************************
	localparam ST_IDLE = 3'd0;
	localparam ST_PEND = 3'd1;
	localparam ST_ACT = 3'd2;
	localparam ST_SUSP = 3'd3;
	localparam ST_PAUSE = 3'd4;

	localparam MC_OFF = 3'd0;
	localparam MC_SW_SS = 3'd1;
	localparam MC_EDGE_SS = 3'd2;
	localparam MC_TMR_SS = 3'd3;
	localparam MC_SW_CS = 3'd4;
	localparam MC_EDGE_CS = 3'd5;
	localparam MC_TMR_CS = 3'd6;

	// mode code to trigger class
	function [2:0] mode_class;
		input [4:0] m;
		begin
			if (m == `Q2SC_M_SW_SS)
				mode_class = MC_SW_SS;
			else if (m == `Q2SC_M_RISE_SS || m == `Q2SC_M_FALL_SS)
				mode_class = MC_EDGE_SS;
			else if (m >= `Q2SC_M_IT_LO && m <= `Q2SC_M_IT_HI)
				mode_class = MC_TMR_SS;
			else if (m == `Q2SC_M_SW_CS)
				mode_class = MC_SW_CS;
			else if (m == `Q2SC_M_RISE_CS || m == `Q2SC_M_FALL_CS)
				mode_class = MC_EDGE_CS;
			else if (m >= `Q2SC_M_PT_LO && m <= `Q2SC_M_PT_HI)
				mode_class = MC_TMR_CS;
			else
				mode_class = MC_OFF;
		end
	endfunction

	// timer exponent: low four code bits plus three gives 7..17
	function [4:0] mode_exp;
		input [4:0] m;
		begin
			mode_exp = {1'b0, m[3:0]} + `Q2SC_EXP_BASE;
		end
	endfunction

	// ****************************************
	// registers
	// ****************************************
	reg wait_q;
	reg [31:0] rdata_q;
	reg cie_q;
	reg pie_q;
	reg arm_q;
	reg [4:0] mode_q;
	reg res_q;
	reg [5:0] bq_q;
	reg test_q;
	reg res_eff_q;
	reg [5:0] bq_eff_q;
	reg [5:0] subq_q;
	reg [5:0] abort_q;
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg start_q;
	reg [5:0] start_addr_q;
	reg q1_end_q;
	reg pin_q;

	wire [2:0] mclass;
	wire single_w;
	wire take_w;
	wire wr_w;
	wire wr_lo_w;
	wire wr_hi_w;
	wire ctrl_wr_w;
	wire [4:0] mode_new_w;
	wire mode_chg_w;
	wire arm_set_w;
	wire rise_w;
	wire fall_w;
	wire edge_w;
	wire tmr_exp_w;
	wire tmr_run_w;
	wire trig_w;
	wire empty_w;
	wire done_end_w;
	wire done_pause_w;

	// ****************************************
	// avalon slave handshake
	// ****************************************
	// one wait cycle per access; the request is taken at the edge where
	// waitrequest is low, read data are loaded one cycle earlier
	assign take_w = (avs_read_i || avs_write_i) && !wait_q;
	assign wr_w = avs_write_i && take_w;
	assign ctrl_wr_w = wr_w && (avs_address_i == `Q2SC_OFS_CTRL);
	assign wr_lo_w = ctrl_wr_w && avs_byteenable_i[0];
	assign wr_hi_w = ctrl_wr_w && avs_byteenable_i[1];

	always @(posedge clk_i) begin
		if (rst_i)
			wait_q <= 1'b1;
		else
			wait_q <= !((avs_read_i || avs_write_i) && wait_q);
	end

	// read mux; arm bit hidden outside test mode
	always @(posedge clk_i) begin
		if (rst_i) begin
			rdata_q <= 32'h00000000;
		end else if (avs_read_i && wait_q) begin
			case (avs_address_i)
			`Q2SC_OFS_CTRL: begin
				rdata_q <= {16'h0000, cie_q, pie_q,
					arm_q & test_q,
					mode_q, res_q, 1'b0, bq_q};
			end
			`Q2SC_OFS_STAT: begin
				rdata_q <= {6'h00, abort_q, 2'b00, subq_q,
					res_eff_q, state_q, 2'b00, bq_eff_q};
			end
			`Q2SC_OFS_TEST: begin
				rdata_q <= {31'h00000000, test_q};
			end
			default: begin
				rdata_q <= 32'h00000000;
			end
			endcase
		end
	end

	assign avs_readdata_o = rdata_q;
	assign avs_waitrequest_o = wait_q;

	// ****************************************
	// control register
	// ****************************************
	assign mode_new_w = wr_hi_w ?
		avs_writedata_i[`Q2SC_MODE_HI:`Q2SC_MODE_LO] : mode_q;
	assign mode_chg_w = wr_hi_w && (mode_new_w != mode_q);
	assign arm_set_w = wr_hi_w && avs_writedata_i[`Q2SC_ARM_BIT];
	assign mclass = mode_class(mode_q);
	assign single_w = (mclass == MC_SW_SS) || (mclass == MC_EDGE_SS) ||
		(mclass == MC_TMR_SS);
	assign done_end_w = (state_q == ST_ACT) && q2_ccw_done_i &&
		q2_eoq_i;
	assign done_pause_w = (state_q == ST_ACT) && q2_ccw_done_i &&
		q2_ccw_pause_i && !q2_eoq_i;

	// mode and arm fields land in the same byte 1 write; the pointer lands with byte 0
	always @(posedge clk_i) begin
		if (rst_i) begin
			cie_q <= `Q2SC_FLAG_RST;
			pie_q <= `Q2SC_FLAG_RST;
			arm_q <= 1'b0;
			mode_q <= `Q2SC_M_OFF;
			res_q <= 1'b0;
			bq_q <= `Q2SC_BQ_RST;
			test_q <= 1'b0;
		end else begin
			if (wr_hi_w) begin
				cie_q <= avs_writedata_i[`Q2SC_CIE_BIT];
				pie_q <= avs_writedata_i[`Q2SC_PIE_BIT];
				mode_q <= mode_new_w;
			end
			// a write that sets the bit beats completion clearing it
			if (arm_set_w)
				arm_q <= 1'b1;
			else if (wr_hi_w)
				arm_q <= 1'b0;
			else if (done_end_w && single_w)
				arm_q <= 1'b0;
			if (wr_lo_w) begin
				res_q <= avs_writedata_i[`Q2SC_RES_BIT];
				bq_q <= avs_writedata_i[`Q2SC_BQ_HI:`Q2SC_BQ_LO];
			end
			if (wr_w && avs_address_i == `Q2SC_OFS_TEST &&
				avs_byteenable_i[0])
				test_q <= avs_writedata_i[0];
		end
	end

	// ****************************************
	// trigger sources
	// ****************************************
	always @(posedge clk_i) begin
		if (rst_i)
			pin_q <= 1'b0;
		else
			pin_q <= q2_trigger_pin_i;
	end

	assign rise_w = q2_trigger_pin_i && !pin_q;
	assign fall_w = !q2_trigger_pin_i && pin_q;
	// code bit 0 picks falling over rising
	assign edge_w = mode_q[0] ? fall_w : rise_w;
	// interval timer only runs while armed; periodic always runs
	assign tmr_run_w = (mclass == MC_TMR_CS) ||
		((mclass == MC_TMR_SS) && arm_q);

	q2sc_timer u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(conversion_clock_tick_i),
		.run_i(tmr_run_w),
		.clear_i(mode_chg_w),
		.exp_i(mode_exp(mode_q)),
		.expire_o(tmr_exp_w)
	);

	// combined trigger event per class
	assign trig_w =
		(mclass == MC_SW_SS) ? arm_q :
		(mclass == MC_EDGE_SS) ? (edge_w && arm_q) :
		(mclass == MC_TMR_SS) ? (tmr_exp_w && arm_q) :
		(mclass == MC_SW_CS) ? 1'b1 :
		(mclass == MC_EDGE_CS) ? edge_w :
		(mclass == MC_TMR_CS) ? tmr_exp_w :
		1'b0;

	// empty queue never starts a scan from idle
	assign empty_w = (bq_eff_q >= `Q2SC_BQ_EMPTY);

	// ****************************************
	// queue 2 sequencing state machine
	// ****************************************
	always @* begin
		state_d = state_q;
		case (state_q)
		ST_IDLE: begin
			if (trig_w && !empty_w && bq_q < `Q2SC_BQ_EMPTY)
				state_d = ST_PEND;
		end
		ST_PEND: begin
			if (!q1_active_i)
				state_d = ST_ACT;
		end
		ST_ACT: begin
			if (q2_suspend_i)
				state_d = ST_SUSP;
			else if (done_pause_w)
				state_d = ST_PAUSE;
			else if (done_end_w)
				state_d = (mclass == MC_SW_CS) ? ST_PEND : ST_IDLE;
		end
		ST_SUSP: begin
			if (!q1_active_i)
				state_d = ST_ACT;
		end
		ST_PAUSE: begin
			if (trig_w)
				state_d = ST_PEND;
		end
		default: begin
			state_d = ST_IDLE;
		end
		endcase
		if (mode_chg_w)
			state_d = ST_IDLE;
	end

	// effective pointer and resume point follow the register only
	// between scans, so a running queue is never torn mid-pass
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			res_eff_q <= 1'b0;
			bq_eff_q <= `Q2SC_BQ_RST;
			subq_q <= `Q2SC_BQ_RST;
			abort_q <= `Q2SC_BQ_RST;
			start_q <= 1'b0;
			start_addr_q <= `Q2SC_BQ_RST;
		end else begin
			state_q <= state_d;
			start_q <= 1'b0;
			if (mode_chg_w || state_q == ST_IDLE || done_end_w) begin
				res_eff_q <= res_q;
				bq_eff_q <= bq_q;
				subq_q <= bq_q;
			end else if (done_pause_w) begin
				// next subqueue; the paused one is not repeated
				subq_q <= q2_cur_addr_i + 6'h01;
			end
			if (state_q == ST_ACT && q2_suspend_i)
				abort_q <= q2_cur_addr_i;
			// fresh scan or continuation after a pause
			if (state_q == ST_PEND && !q1_active_i &&
				!mode_chg_w) begin
				start_q <= 1'b1;
				start_addr_q <= subq_q;
			end
			// resume after queue 1 lets go
			if (state_q == ST_SUSP && !q1_active_i &&
				!mode_chg_w) begin
				start_q <= 1'b1;
				start_addr_q <= res_eff_q ? abort_q :
					subq_q;
			end
		end
	end

	assign q2_start_o = start_q;
	assign q2_start_addr_o = start_addr_q;
	assign q2_state_o = state_q;

	// ****************************************
	// queue 1 end-of-queue boundary
	// ****************************************
	// compared on each fetch against the live register value, so a
	// word already in conversion always completes first
	always @(posedge clk_i) begin
		if (rst_i)
			q1_end_q <= 1'b0;
		else
			q1_end_q <= q1_fetch_i &&
				(q1_fetch_addr_i == bq_q);
	end

	assign q1_end_o = q1_end_q;

endmodule // q2sc_top

// *** bench/q2sc_chk.sv ***
`timescale 1ns/100ps
// ****
// port checker for the queue 2 control block
// ****
module q2sc_chk (
	input wire clk_i,
	input wire rst_i,
	input wire [3:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	input wire avs_waitrequest_o,
	input wire q1_active_i,
	input wire q1_fetch_i,
	input wire [5:0] q1_fetch_addr_i,
	input wire q1_end_o,
	input wire q2_start_o,
	input wire [5:0] q2_start_addr_o,
	input wire [2:0] q2_state_o
);
	reg [5:0] ptr_q;
	reg [4:0] mode_q;
	wire req = avs_read_i || avs_write_i;
	wire take = avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0;
	wire off = mode_q == 5'h00 || mode_q == 5'h0f || mode_q == 5'h10 ||
		mode_q == 5'h1f;
	// shadow of the written fields; compares must use the live pointer
	always @(posedge clk_i) begin
		if (rst_i) begin
			ptr_q <= 6'h27;
			mode_q <= 5'h00;
		end else if (take) begin
			if (avs_byteenable_i[0])
				ptr_q <= avs_writedata_i[5:0];
			if (avs_byteenable_i[1])
				mode_q <= avs_writedata_i[12:8];
		end
	end
	// a mode-changing write at that edge sends the queue back to idle
	sequence s_ready;
		q2_state_o == 3'd1 && !q1_active_i && !(take &&
			avs_byteenable_i[1] && avs_writedata_i[12:8] != mode_q);
	endsequence
	sequence s_go;
		q2_start_o && q2_state_o == 3'd2;
	endsequence
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_wait_one: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("waitrequest did not drop");
	a_wait_rel: assert property (req && !avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest did not rise");
	a_q1_end_match: assert property (q1_end_o == $past(q1_fetch_i &&
		q1_fetch_addr_i == ptr_q)) else $error("queue 1 end wrong");
	a_start_pulse: assert property (q2_start_o |=> !q2_start_o)
		else $error("start longer than one cycle");
	a_pend_start: assert property (s_ready |=> s_go)
		else $error("pending start not issued");
	a_start_q1_idle: assert property (q2_start_o |-> !$past(q1_active_i))
		else $error("start while queue 1 busy");
	a_off_idle: assert property (off && q2_state_o == 3'd0 |=>
		q2_state_o == 3'd0) else $error("off mode left idle");
	a_bq_empty: assert property (ptr_q >= 6'd40 && q2_state_o == 3'd0
		|=> q2_state_o == 3'd0) else $error("empty queue left idle");
	a_addr_hold: assert property (!q2_start_o |-> $stable(q2_start_addr_o))
		else $error("start address moved");
endmodule // q2sc_chk

bind q2sc_top q2sc_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
	.avs_byteenable_i(avs_byteenable_i), .avs_waitrequest_o(avs_waitrequest_o),
	.q1_active_i(q1_active_i), .q1_fetch_i(q1_fetch_i),
	.q1_fetch_addr_i(q1_fetch_addr_i), .q1_end_o(q1_end_o),
	.q2_start_o(q2_start_o), .q2_start_addr_o(q2_start_addr_o),
	.q2_state_o(q2_state_o));

// *** bench/q2sc_far.sv ***
`timescale 1ns/100ps
// ****
// conversion clock and trigger pin source
// ****
module q2sc_far #(
	parameter [3:0] TICK_LAST = 4'h1
) (
	input wire clk_i,
	input wire rst_i,
	input wire pin_req_i,
	output reg tick_o,
	output reg pin_o
);
	reg [3:0] cnt_q;
	// tick every TICK_LAST+1 cycles; pin follows request one cycle late
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 4'h0;
			tick_o <= 1'b0;
			pin_o <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == TICK_LAST) ? 4'h0 : cnt_q + 4'h1;
			tick_o <= cnt_q == 4'h0;
			pin_o <= pin_req_i;
		end
	end
endmodule // q2sc_far

// *** bench/test_q2sc_top.sv ***
`timescale 1ns/100ps
module test_q2sc_top;
	reg clk_i = 1'b0;
	reg rst_i = 1'b1;
	reg [3:0] avs_address_i = 4'h0;
	reg [31:0] avs_writedata_i = 32'h0;
	reg avs_read_i = 1'b0, avs_write_i = 1'b0, pin_req = 1'b0;
	reg q1_active_i = 1'b0, q1_fetch_i = 1'b0, q2_suspend_i = 1'b0;
	reg q2_ccw_done_i = 1'b0, q2_ccw_pause_i = 1'b0, q2_eoq_i = 1'b0;
	reg [5:0] q1_fetch_addr_i = 6'h0, q2_cur_addr_i = 6'h0;
	wire [31:0] avs_readdata_o;
	wire avs_waitrequest_o, tick, pin, q1_end_o, q2_start_o;
	wire [5:0] q2_start_addr_o;
	wire [2:0] q2_state_o;
	integer failures = 0, check_count = 0, n, i;
	reg [31:0] rv;
	reg [24:0] tbl = {5'h01, 5'h1f, 5'h10, 5'h0f, 5'h00};
	reg [19:0] etbl = {5'h13, 5'h12, 5'h03, 5'h02};
	// free-running system clock
	always #5 clk_i = ~clk_i;
	q2sc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.conversion_clock_tick_i(tick), .q2_trigger_pin_i(pin),
		.q1_active_i(q1_active_i), .q1_fetch_i(q1_fetch_i),
		.q1_fetch_addr_i(q1_fetch_addr_i), .q2_suspend_i(q2_suspend_i),
		.q2_cur_addr_i(q2_cur_addr_i), .q2_ccw_done_i(q2_ccw_done_i),
		.q2_ccw_pause_i(q2_ccw_pause_i), .q2_eoq_i(q2_eoq_i),
		.q1_end_o(q1_end_o), .q2_start_o(q2_start_o),
		.q2_start_addr_o(q2_start_addr_o), .q2_state_o(q2_state_o));
	q2sc_far u_far (.clk_i(clk_i), .rst_i(rst_i), .pin_req_i(pin_req),
		.tick_o(tick), .pin_o(pin));
	// ****
	// helpers
	// ****
	task results;
		$display("failures %0d check_count %0d", failures, check_count);
		if (failures == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string s, input [31:0] e, input [31:0] g);
		check_count = check_count + 1;
		if (g !== e) begin
			failures = failures + 1;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	// one bus access held until waitrequest is sampled low
	task bus(input w, input [3:0] a, input [31:0] d);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		n = 0;
		do begin
			@(posedge clk_i);
			n = n + 1;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		rv = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		if (avs_waitrequest_o !== 1'b0) begin
			chk("bus answer", 0, 1);
			results;
		end
	endtask
	task ctl(input [4:0] m, input arm, input [5:0] bq);
		bus(1'b1, 4'h0, {18'h0, arm, m, 2'b00, bq});
	endtask
	task rd(input [3:0] a, input [31:0] e, input string s);
		bus(1'b0, a, 32'h0);
		chk(s, e, rv);
	endtask
	task wstart(input [5:0] a);
		n = 0;
		do begin
			@(posedge clk_i);
			n = n + 1;
		end while (q2_start_o !== 1'b1 && n < 600);
		chk("start addr", {26'h0, a}, {26'h0, q2_start_addr_o});
		if (q2_start_o !== 1'b1) begin
			chk("start seen", 1, 0);
			results;
		end
	endtask
	task nostart;
		n = 0;
		repeat (20) begin
			@(posedge clk_i);
			if (q2_start_o !== 1'b0)
				n = n + 1;
		end
		chk("no start", 0, n);
	endtask
	task fin;
		@(posedge clk_i);
		q2_ccw_done_i <= 1'b1;
		q2_eoq_i <= 1'b1;
		@(posedge clk_i);
		q2_ccw_done_i <= 1'b0;
		q2_eoq_i <= 1'b0;
	endtask
	// one converted word carrying the pause bit at location a
	task pz(input [5:0] a);
		@(posedge clk_i);
		q2_ccw_done_i <= 1'b1;
		q2_ccw_pause_i <= 1'b1;
		q2_cur_addr_i <= a;
		@(posedge clk_i);
		q2_ccw_done_i <= 1'b0;
		q2_ccw_pause_i <= 1'b0;
	endtask
	// queue 1 pre-empts at location a, then lets go again
	task sus(input [5:0] a);
		@(posedge clk_i);
		q1_active_i <= 1'b1;
		q2_suspend_i <= 1'b1;
		q2_cur_addr_i <= a;
		@(posedge clk_i);
		q2_suspend_i <= 1'b0;
		@(posedge clk_i);
		chk("state susp", 3, q2_state_o);
		q1_active_i <= 1'b0;
	endtask
	task fe(input [5:0] a, input e);
		@(posedge clk_i);
		q1_fetch_i <= 1'b1;
		q1_fetch_addr_i <= a;
		@(posedge clk_i);
		q1_fetch_i <= 1'b0;
		@(posedge clk_i);
		chk("q1 end", {31'h0, e}, {31'h0, q1_end_o});
	endtask
	// ****
	// scenarios
	// ****
	task t_regs;
		rd(4'h0, 32'h27, "ctrl reset");
		bus(1'b1, 4'hc, 32'hffff);
		rd(4'hc, 32'h0, "unmapped");
	endtask
	task t_sw;
		@(posedge clk_i);
		q1_active_i <= 1'b1;
		ctl(5'h01, 1'b1, 6'h05);
		nostart;
		@(posedge clk_i);
		q1_active_i <= 1'b0;
		wstart(6'h05);
		rd(4'h0, 32'h105, "arm hidden");
		bus(1'b1, 4'h8, 32'h1);
		rd(4'h0, 32'h2105, "arm in test");
		fin;
		rd(4'h0, 32'h105, "arm cleared");
		bus(1'b1, 4'h8, 32'h0);
		nostart;
	endtask
	// edge modes: pin parked at the idle level, then one edge
	task t_edge;
		ctl(5'h02, 1'b0, 6'h07);
		@(posedge clk_i);
		pin_req <= 1'b1;
		nostart;
		for (i = 0; i < 4; i = i + 1) begin
			ctl(5'h00, 1'b0, 6'h07);
			@(posedge clk_i);
			pin_req <= etbl[i*5];
			repeat (3) @(posedge clk_i);
			ctl(etbl[i*5 +: 5], 1'b1, 6'h07);
			@(posedge clk_i);
			pin_req <= !etbl[i*5];
			wstart(6'h07);
			fin;
		end
	endtask
	task t_off;
		for (i = 0; i < 5; i = i + 1) begin
			ctl(tbl[i*5 +: 5], 1'b1, (i == 4) ? 6'd40 : 6'd5);
			@(posedge clk_i);
			pin_req <= 1'b0;
			@(posedge clk_i);
			pin_req <= 1'b1;
			nostart;
		end
	endtask
	task t_cont;
		ctl(5'h11, 1'b0, 6'h0a);
		wstart(6'h0a);
		ctl(5'h11, 1'b0, 6'h10);
		@(posedge clk_i);
		q1_active_i <= 1'b1;
		q2_suspend_i <= 1'b1;
		q2_cur_addr_i <= 6'h0c;
		@(posedge clk_i);
		q2_suspend_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		q1_active_i <= 1'b0;
		wstart(6'h0a);
		fin;
		wstart(6'h10);
		ctl(5'h00, 1'b0, 6'h10);
	endtask
	// 2^7 ticks, one tick every two cycles
	task t_timer;
		for (i = 0; i < 2; i = i + 1) begin
			ctl(5'h00, 1'b0, 6'h02);
			ctl(i ? 5'h14 : 5'h04, 1'b1, 6'h02);
			wstart(6'h02);
			chk("timer span", 1, n >= 250 && n <= 262);
			fin;
		end
		ctl(5'h00, 1'b0, 6'h02);
	endtask
	task t_q1;
		ctl(5'h00, 1'b0, 6'h03);
		fe(6'h02, 1'b0);
		fe(6'h03, 1'b1);
		ctl(5'h00, 1'b0, 6'h02);
		fe(6'h02, 1'b1);
		ctl(5'h00, 1'b0, 6'h00);
		fe(6'h00, 1'b1);
	endtask
	// software continuous with resume-select set, then cleared mid-scan
	task t_res;
		bus(1'b1, 4'h0, 32'h1184);
		wstart(6'h04);
		chk("state act", 2, q2_state_o);
		pz(6'h05);
		wstart(6'h06);
		sus(6'h08);
		wstart(6'h08);
		bus(1'b1, 4'h0, 32'h1104);
		sus(6'h09);
		wstart(6'h09);
		fin;
		wstart(6'h04);
		sus(6'h0a);
		wstart(6'h04);
		ctl(5'h00, 1'b0, 6'h04);
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs;
		t_sw;
		t_edge;
		t_off;
		t_cont;
		t_timer;
		t_q1;
		t_res;
		results;
	end
endmodule // test_q2sc_top
